// >>> mbexr_check.sv
// Query checker: exception selection, recalculation trigger, power-off store
// What this block does
// - Unsupported function code answers with exception code 01h.
// - Function or target not found answers with exception code 02h.
// - Unacceptable data format answers with exception code 03h.
// - Holding register write value out of range answers with 21h.
// - Writes to run-locked registers during operation answer with 22h.
// - Recalculation trigger while running or undervoltage answers with 22h.
// - Any write to a writable register while tripped or undervoltage answers with 22h; read-only targets answer 23h.
// - Register writes under parameter softlock answer with 22h, except the recalculation trigger, which softlock does not block.
// - Reassigning a terminal not changeable now answers with 22h.
// - Changing trip-reset terminal from NO to NC answers with 22h.
// - Writes to read-only registers or coils answer with exception 23h.
// - Writing 0000h to register 0900h via function 06h recalculates.
// - Listed motor parameters take effect only after a recalculation.
// - No save command; parameters stored automatically at power removal.
// - Exception answer: slave address, function plus 80h, code; CRC downstream.
// - Broadcast queries rejected; addressed queries always answered.
module mbexr_check
  import mbexr_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          q_valid,
  input  wire logic [7:0]    q_slave_addr,
  input  wire logic [7:0]    q_func,
  input  wire logic [15:0]   q_addr,
  input  wire logic [15:0]   q_count,
  input  wire logic [7:0]    q_byte_count,
  input  wire logic [15:0]   q_data,
  input  wire logic          q_format_ok,
  input  wire logic          tgt_exists,
  input  wire logic          tgt_readonly,
  input  wire logic          tgt_no_change_in_run,
  input  wire logic          tgt_in_range,
  input  wire logic          tgt_terminal_fixed,
  input  wire logic          tgt_reset_no_to_nc,
  input  wire logic [2:0]    tgt_param_sel,
  input  wire logic          drv_running,
  input  wire logic          drv_tripped,
  input  wire logic          undervoltage_state,
  input  wire logic          softlock,
  input  wire logic          power_down,
  output logic               resp_valid,
  output logic               resp_exception,
  output logic [7:0]         resp_slave_addr,
  output logic [7:0]         resp_func,
  output logic [7:0]         resp_code,
  output logic               wr_commit,
  output logic               recalc_done,
  output logic               store_req,
  output mbexr_params_t      param_active
);
  mbexr_recalc_if rc ();

  mbexr_store u_store (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .rc      (rc)
  );

  function automatic logic fn_is_write(input logic [7:0] fc);
    return (fc == FC_WR_COIL) || (fc == FC_WR_SINGLE) || (fc == FC_WR_COILS) ||
           (fc == FC_WR_MULTI) || (fc == FC_RDWR_MULTI);
  endfunction : fn_is_write

  function automatic logic fn_supported(input logic [7:0] fc);
    return (fc == FC_RD_COILS) || (fc == FC_RD_REGS) || fn_is_write(fc);
  endfunction : fn_supported

  logic        is_broadcast;
  logic        is_write;
  logic        is_recalc;
  logic        bad_bytes;
  logic [7:0]  next_code;
  logic        accept;
  logic        power_down_d;

  assign is_broadcast = (q_slave_addr == BROADCAST_ADDR);
  assign is_write     = fn_is_write(q_func);
  // Line address is the register number minus one
  assign is_recalc    = (q_func == FC_WR_SINGLE) && (q_addr == RECALC_LINE_ADDR);
  assign bad_bytes    = ((q_func == FC_WR_MULTI) || (q_func == FC_RDWR_MULTI)) &&
                        ({1'b0, q_count, 1'b0} != {10'h000, q_byte_count});

  // First matching fault wins, so only one code is ever reported
  always_comb
  begin
    next_code = EXC_NONE;
    if (!fn_supported(q_func))
      next_code = EXC_UNSUPPORTED;
    else if (!tgt_exists && !is_recalc)
      next_code = EXC_NOT_FOUND;
    else if (!q_format_ok || bad_bytes)
      next_code = EXC_BAD_FORMAT;
    else if (is_recalc)
    begin
      if (drv_running || undervoltage_state || drv_tripped)
        next_code = EXC_REFUSED;
      else if (q_data != RECALC_VALUE)
        next_code = EXC_RANGE;
    end
    else if (is_write)
    begin
      if (tgt_readonly)
        next_code = EXC_READ_ONLY;
      else if (drv_tripped || undervoltage_state)
        next_code = EXC_REFUSED;
      else if (softlock)
        next_code = EXC_REFUSED;
      else if (tgt_no_change_in_run && drv_running)
        next_code = EXC_REFUSED;
      else if (tgt_terminal_fixed)
        next_code = EXC_REFUSED;
      else if (tgt_reset_no_to_nc)
        next_code = EXC_REFUSED;
      else if (!tgt_in_range)
        next_code = EXC_RANGE;
    end
  end

  assign accept = q_valid && !is_broadcast;

  // Store side only sees writes that passed every check
  assign rc.wr   = accept && is_write && !is_recalc && (next_code == EXC_NONE);
  assign rc.idx  = tgt_param_sel;
  assign rc.data = q_data;
  assign rc.trig = accept && is_recalc && (next_code == EXC_NONE);
  assign param_active = rc.active;
  assign recalc_done  = rc.done;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      resp_valid <= 1'b0;
    else
      resp_valid <= accept;
  end

  // Answer fields, exception form carries function plus 80h
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      resp_exception  <= 1'b0;
      resp_slave_addr <= 8'h00;
      resp_func       <= 8'h00;
      resp_code       <= EXC_NONE;
    end
    else if (accept)
    begin
      resp_exception  <= (next_code != EXC_NONE);
      resp_slave_addr <= q_slave_addr;
      resp_func       <= (next_code != EXC_NONE) ? (q_func | FC_EXC_FLAG) : q_func;
      resp_code       <= next_code;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      wr_commit <= 1'b0;
    else
      wr_commit <= rc.wr || rc.trig;
  end

  // Parameters are saved on power removal, not by command
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      power_down_d <= 1'b0;
      store_req    <= 1'b0;
    end
    else
    begin
      power_down_d <= power_down;
      store_req    <= power_down && !power_down_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_unsup;
    q_valid && !is_broadcast && !fn_supported(q_func);
  endsequence
  sequence s_exc_answer(logic [7:0] code);
    resp_valid && resp_exception && resp_code == code;
  endsequence
  sequence s_recalc_ok;
    q_valid && !is_broadcast && q_func == FC_WR_SINGLE && q_addr == RECALC_LINE_ADDR &&
    q_data == RECALC_VALUE && q_format_ok && !drv_running && !drv_tripped && !undervoltage_state;
  endsequence
  sequence s_query;
    q_valid && !is_broadcast;
  endsequence
  sequence s_wr_open;
    q_valid && !is_broadcast && is_write && !is_recalc && tgt_exists && q_format_ok && !bad_bytes &&
    !tgt_readonly;
  endsequence
  sequence s_wr_clear;
    s_wr_open ##0 (!drv_tripped && !undervoltage_state && !softlock &&
    !(tgt_no_change_in_run && drv_running) && !tgt_terminal_fixed && !tgt_reset_no_to_nc);
  endsequence

  AST_UNSUPPORTED: assert property (s_unsup |=> s_exc_answer(EXC_UNSUPPORTED))
    else $error("unsupported function not answered with 01h");

  AST_NOT_FOUND: assert property (
    s_query ##0 (fn_supported(q_func) && !tgt_exists && !is_recalc) |=> s_exc_answer(EXC_NOT_FOUND))
    else $error("missing target not answered with 02h");

  AST_BAD_FORMAT: assert property (
    s_query ##0 (fn_supported(q_func) && (tgt_exists || is_recalc) && (!q_format_ok || bad_bytes))
    |=> s_exc_answer(EXC_BAD_FORMAT))
    else $error("bad data format not answered with 03h");

  AST_RANGE: assert property (
    s_wr_clear ##0 !tgt_in_range |=> s_exc_answer(EXC_RANGE) ##0 !wr_commit)
    else $error("out of range write not answered with 21h");

  AST_RECALC_DATA: assert property (
    s_query ##0 (is_recalc && q_format_ok && !drv_running && !drv_tripped && !undervoltage_state &&
    q_data != RECALC_VALUE) |=> s_exc_answer(EXC_RANGE) ##0 !recalc_done)
    else $error("non-zero trigger value not answered with 21h");

  AST_RUN_LOCK: assert property (
    s_wr_open ##0 (tgt_no_change_in_run && drv_running) |=> s_exc_answer(EXC_REFUSED) ##0 !wr_commit)
    else $error("run-locked write during run not refused with 22h");

  AST_RECALC_RUN: assert property (
    q_valid && !is_broadcast && is_recalc && q_format_ok && drv_running
    |=> s_exc_answer(EXC_REFUSED) ##0 !recalc_done)
    else $error("recalculation during run not refused with 22h");

  AST_RECALC_UV: assert property (
    s_query ##0 (is_recalc && q_format_ok && (undervoltage_state || drv_tripped))
    |=> s_exc_answer(EXC_REFUSED) ##0 !recalc_done)
    else $error("recalculation in undervoltage or trip not refused with 22h");

  AST_TRIP_WRITE: assert property (
    s_wr_open ##0 (drv_tripped || undervoltage_state) |=> s_exc_answer(EXC_REFUSED) ##0 !wr_commit)
    else $error("write while tripped not refused with 22h");

  AST_SOFTLOCK: assert property (s_wr_open ##0 softlock |=> resp_code == EXC_REFUSED)
    else $error("write under softlock not refused with 22h");

  AST_TERMINAL: assert property (
    s_wr_open ##0 tgt_terminal_fixed |=> s_exc_answer(EXC_REFUSED) ##0 !wr_commit)
    else $error("fixed terminal reassignment not refused with 22h");

  AST_NO_TO_NC: assert property (
    s_wr_open ##0 tgt_reset_no_to_nc |=> s_exc_answer(EXC_REFUSED) ##0 !wr_commit)
    else $error("reset terminal logic change not refused with 22h");

  AST_READ_ONLY: assert property (
    q_valid && !is_broadcast && is_write && !is_recalc && tgt_exists &&
    q_format_ok && !bad_bytes && tgt_readonly |=> s_exc_answer(EXC_READ_ONLY))
    else $error("read-only write not answered with 23h");

  AST_RECALC: assert property (s_recalc_ok |=> wr_commit && recalc_done)
    else $error("recalculation trigger not performed");

  AST_RECALC_PAIR: assert property (recalc_done |-> wr_commit)
    else $error("recalculation without an accepted trigger");

  AST_PENDING: assert property (
    rc.wr && rc.idx != PARAM_NONE && !rc.trig |=> param_active == $past(param_active))
    else $error("parameter took effect without recalculation");

  AST_PENDING_APPLY: assert property (rc.trig |=> param_active == $past(u_store.pending))
    else $error("recalculation did not apply pending parameters");

  AST_WRITE_OK: assert property (
    s_wr_clear ##0 tgt_in_range |=> resp_valid && !resp_exception && wr_commit)
    else $error("clean write not committed");

  AST_STORE: assert property ($rose(power_down) |=> store_req ##1 !store_req)
    else $error("power-off store request not a single pulse");

  AST_STORE_HOLD: assert property (
    $past(rstn, 2) && $past(power_down, 2) && $past(power_down) |-> !store_req)
    else $error("power-off store repeated while power stays off");

  AST_EXC_FUNC: assert property (
    resp_valid && resp_exception |-> resp_func == ($past(q_func) | FC_EXC_FLAG) &&
    resp_slave_addr == $past(q_slave_addr))
    else $error("exception function code not query plus 80h");

  AST_HOLD_FIELDS: assert property (
    !(q_valid && !is_broadcast) |=> $stable(resp_code) && $stable(resp_func) &&
    $stable(resp_slave_addr) && $stable(resp_exception))
    else $error("answer fields changed without a query");

  AST_BROADCAST: assert property (q_valid && is_broadcast |=> !resp_valid && !wr_commit)
    else $error("broadcast query was answered");

  AST_ADDRESSED: assert property (q_valid && !is_broadcast |=> resp_valid)
    else $error("addressed query got no answer");

  AST_READ_OK: assert property (
    s_query ##0 ((q_func == FC_RD_COILS || q_func == FC_RD_REGS) && tgt_exists && q_format_ok)
    |=> resp_valid && !resp_exception && resp_func == $past(q_func) && !wr_commit)
    else $error("valid read not answered normally");

  AST_NO_CHANGE: assert property (resp_valid && resp_exception |-> !wr_commit)
    else $error("target changed despite exception");
endmodule : mbexr_check

// >>> mbexr_master.sv
// Query source standing in for the bus master
module mbexr_master
(
  input  wire logic  ref_clk,
  output logic       q_valid,
  output logic [7:0] q_slave_addr,
  output logic [7:0] q_func,
  output logic [15:0] q_addr,
  output logic [15:0] q_count,
  output logic [7:0] q_byte_count,
  output logic [15:0] q_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {q_valid, q_slave_addr, q_func, q_addr, q_count, q_byte_count, q_data} = '0;
  // One query, launched at a falling edge
  task automatic send(input logic [7:0] sa, fn, bc, input logic [15:0] ad, cnt, dt);
    {q_valid, q_slave_addr, q_func, q_addr, q_count, q_byte_count, q_data} = {1'b1, sa, fn, ad, cnt, bc, dt};
    @(negedge ref_clk);
    q_valid = 1'b0;
    // Released fields no longer hold
    {q_slave_addr, q_func, q_addr, q_data} = ~{sa, fn, ad, dt};
  endtask : send
endmodule : mbexr_master

// >>> mbexr_pkg.sv
// Constants and types shared by the exception and recalculation logic
package mbexr_pkg;
  localparam logic [7:0]  FC_RD_COILS     = 8'h01;
  localparam logic [7:0]  FC_RD_REGS      = 8'h03;
  localparam logic [7:0]  FC_WR_COIL      = 8'h05;
  localparam logic [7:0]  FC_WR_SINGLE    = 8'h06;
  localparam logic [7:0]  FC_WR_COILS     = 8'h0f;
  localparam logic [7:0]  FC_WR_MULTI     = 8'h10;
  localparam logic [7:0]  FC_RDWR_MULTI   = 8'h17;
  localparam logic [7:0]  FC_EXC_FLAG     = 8'h80;
  localparam logic [7:0]  BROADCAST_ADDR  = 8'h00;
  localparam logic [7:0]  EXC_NONE        = 8'h00;
  localparam logic [7:0]  EXC_UNSUPPORTED = 8'h01;
  localparam logic [7:0]  EXC_NOT_FOUND   = 8'h02;
  localparam logic [7:0]  EXC_BAD_FORMAT  = 8'h03;
  localparam logic [7:0]  EXC_RANGE       = 8'h21;
  localparam logic [7:0]  EXC_REFUSED     = 8'h22;
  localparam logic [7:0]  EXC_READ_ONLY   = 8'h23;
  localparam logic [15:0] RECALC_TRIGGER  = 16'h0900;
  localparam logic [15:0] RECALC_LINE_ADDR = 16'h08ff;
  localparam logic [15:0] RECALC_VALUE    = 16'h0000;
  localparam int          PARAM_NUM       = 7;
  localparam logic [2:0]  PARAM_NONE      = 3'h7;
  localparam logic [15:0] PARAM_RESET     = 16'h0000;
  typedef logic [PARAM_NUM-1:0][15:0] mbexr_params_t;
endpackage : mbexr_pkg

// >>> mbexr_recalc_if.sv
// Carrier between the query checker and the parameter store
interface mbexr_recalc_if;
  import mbexr_pkg::*;
  logic          wr;
  logic [2:0]    idx;
  logic [15:0]   data;
  logic          trig;
  mbexr_params_t active;
  logic          done;
  modport ctl   (output wr, idx, data, trig, input active, done);
  modport store (input wr, idx, data, trig, output active, done);
endinterface : mbexr_recalc_if

// >>> mbexr_store.sv
// Pending and active copies of parameters that need a recalculation
module mbexr_store
  import mbexr_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rstn,
  mbexr_recalc_if.store rc
);
  mbexr_params_t pending;

  // Accepted writes land in the pending copy only
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      pending <= {PARAM_NUM{PARAM_RESET}};
    else if (rc.wr && rc.idx != PARAM_NONE)
      pending[rc.idx] <= rc.data;
  end

  // Trigger copies everything pending into the active set
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rc.active <= {PARAM_NUM{PARAM_RESET}};
    else if (rc.trig)
      rc.active <= pending;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rc.done <= 1'b0;
    else
      rc.done <= rc.trig;
  end
endmodule : mbexr_store

// >>> modbus_exception_and_recalc_tb_top.sv
// Self-checking bench for the query checker
module modbus_exception_and_recalc_tb_top import mbexr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
  logic          ref_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          q_valid, q_format_ok, tgt_exists, tgt_readonly, tgt_no_change_in_run, tgt_in_range;
  logic          tgt_terminal_fixed, tgt_reset_no_to_nc, drv_running, drv_tripped, undervoltage_state;
  logic          softlock, power_down, resp_valid, resp_exception, wr_commit, recalc_done, store_req;
  logic [2:0]    tgt_param_sel;
  logic [7:0]    q_slave_addr, q_func, q_byte_count, resp_slave_addr, resp_func, resp_code, sa, fn, bc;
  logic [15:0]   q_addr, q_count, q_data, ad, cnt, dt;
  mbexr_params_t param_active, act, pend;
  int            n_fail = 0, n_tests = 0, seed = 81, k;
  logic [7:0]    fns [8] = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h17, 8'h2b};

  always #2.5 ref_clk = ~ref_clk;
  mbexr_master m (
    .ref_clk      (ref_clk),
    .q_valid      (q_valid),
    .q_slave_addr (q_slave_addr),
    .q_func       (q_func),
    .q_addr       (q_addr),
    .q_count      (q_count),
    .q_byte_count (q_byte_count),
    .q_data       (q_data)
  );
  mbexr_check DUT (
    .ref_clk              (ref_clk),
    .rstn                 (rstn),
    .q_valid              (q_valid),
    .q_slave_addr         (q_slave_addr),
    .q_func               (q_func),
    .q_addr               (q_addr),
    .q_count              (q_count),
    .q_byte_count         (q_byte_count),
    .q_data               (q_data),
    .q_format_ok          (q_format_ok),
    .tgt_exists           (tgt_exists),
    .tgt_readonly         (tgt_readonly),
    .tgt_no_change_in_run (tgt_no_change_in_run),
    .tgt_in_range         (tgt_in_range),
    .tgt_terminal_fixed   (tgt_terminal_fixed),
    .tgt_reset_no_to_nc   (tgt_reset_no_to_nc),
    .tgt_param_sel        (tgt_param_sel),
    .drv_running          (drv_running),
    .drv_tripped          (drv_tripped),
    .undervoltage_state   (undervoltage_state),
    .softlock             (softlock),
    .power_down           (power_down),
    .resp_valid           (resp_valid),
    .resp_exception       (resp_exception),
    .resp_slave_addr      (resp_slave_addr),
    .resp_func            (resp_func),
    .resp_code            (resp_code),
    .wr_commit            (wr_commit),
    .recalc_done          (recalc_done),
    .store_req            (store_req),
    .param_active         (param_active)
  );

  function automatic logic [7:0] exp_code();
    logic rc;
    rc = fn == FC_WR_SINGLE && ad == RECALC_LINE_ADDR;
    if (!(fn inside {FC_RD_COILS, FC_RD_REGS, FC_WR_COIL, FC_WR_SINGLE, FC_WR_COILS, FC_WR_MULTI, FC_RDWR_MULTI}))
      return EXC_UNSUPPORTED;
    if (!tgt_exists && !rc)
      return EXC_NOT_FOUND;
    if (!q_format_ok || (fn inside {FC_WR_MULTI, FC_RDWR_MULTI} && 17'(bc) != 17'(cnt) * 2))
      return EXC_BAD_FORMAT;
    if (rc)
      return (drv_running | undervoltage_state | drv_tripped) ? EXC_REFUSED : (dt != RECALC_VALUE) ? EXC_RANGE : EXC_NONE;
    if (fn inside {FC_RD_COILS, FC_RD_REGS})
      return EXC_NONE;
    if (tgt_readonly)
      return EXC_READ_ONLY;
    if (drv_tripped | undervoltage_state | softlock | (tgt_no_change_in_run & drv_running) | tgt_terminal_fixed |
        tgt_reset_no_to_nc)
      return EXC_REFUSED;
    return tgt_in_range ? EXC_NONE : EXC_RANGE;
  endfunction : exp_code

  task automatic clean();
    {sa, fn, ad, cnt, bc, dt} = {8'h08, FC_WR_SINGLE, 16'h1102, 16'h0001, 8'h02, 16'h1234};
    {q_format_ok, tgt_exists, tgt_in_range} = '1;
    {tgt_readonly, tgt_no_change_in_run, tgt_terminal_fixed, tgt_reset_no_to_nc} = '0;
    {drv_running, drv_tripped, undervoltage_state, softlock} = '0;
    tgt_param_sel = PARAM_NONE;
  endtask : clean

  task automatic ask();
    logic [7:0] c;
    logic       w;
    logic       ok;
    c = exp_code();
    w = fn == FC_WR_SINGLE && ad == RECALC_LINE_ADDR;
    ok = sa != BROADCAST_ADDR && c == EXC_NONE && !(fn inside {FC_RD_COILS, FC_RD_REGS});
    if (ok && !w && tgt_param_sel != PARAM_NONE)
      pend[tgt_param_sel] = dt;
    if (ok && w)
      act = pend;
    m.send(sa, fn, bc, ad, cnt, dt);
    `CHK("valid", sa != BROADCAST_ADDR, resp_valid)
    `CHK("commit", ok, wr_commit)
    `CHK("recalc", ok && w, recalc_done)
    `CHK("params", act, param_active)
    if (sa != BROADCAST_ADDR)
    begin
      `CHK("code", c, resp_code)
      `CHK("func", c != EXC_NONE ? fn | FC_EXC_FLAG : fn, resp_func)
      `CHK("addr", sa, resp_slave_addr)
      `CHK("exc", c != EXC_NONE, resp_exception)
    end
    @(negedge ref_clk);
    `CHK("valid end", 1'b0, resp_valid)
    `CHK("recalc end", 1'b0, recalc_done)
  endtask : ask

  task automatic summarize();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial
  begin
    clean();
    power_down = 1'b0;
    act = {PARAM_NUM{PARAM_RESET}};
    pend = act;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    `CHK("rst valid", 1'b0, resp_valid)
    `CHK("rst params", act, param_active)
    fn = 8'h02;
    ask();
    clean();
    tgt_exists = 1'b0;
    ask();
    clean();
    {fn, cnt, bc} = {FC_WR_MULTI, 16'h0002, 8'h03};
    ask();
    for (int i = 0; i < 9; i++)
    begin
      clean();
      {tgt_readonly, drv_tripped, undervoltage_state, softlock, tgt_terminal_fixed, tgt_reset_no_to_nc} = 6'(7'h40 >> i);
      {tgt_no_change_in_run, drv_running} = {2{i == 7}};
      tgt_in_range = i != 8;
      ask();
    end
    clean();
    {tgt_param_sel, dt} = {3'h2, 16'habcd};
    ask();
    for (int i = 0; i < 5; i++)
    begin
      clean();
      {ad, dt} = {RECALC_TRIGGER - 16'h0001, i == 4 ? 16'h0001 : RECALC_VALUE};
      {drv_running, undervoltage_state} = 2'(i);
      ask();
    end
    clean();
    sa = BROADCAST_ADDR;
    ask();
    repeat (400)
    begin
      sa = 8'($random(seed));
      fn = fns[$random(seed) & 7];
      ad = ($random(seed) & 3) == 0 ? RECALC_LINE_ADDR : 16'($random(seed));
      cnt = 16'($random(seed) & 3) + 16'h0001;
      bc = ($random(seed) & 7) == 0 ? 8'h03 : 8'(cnt * 2);
      dt = ($random(seed) & 1) ? RECALC_VALUE : 16'($random(seed));
      {tgt_readonly, tgt_no_change_in_run, tgt_terminal_fixed, tgt_reset_no_to_nc, drv_running, drv_tripped,
       undervoltage_state, softlock} = 8'($random(seed)) & 8'($random(seed)) & 8'($random(seed));
      {q_format_ok, tgt_exists, tgt_in_range} = ~(3'($random(seed)) & 3'($random(seed)));
      tgt_param_sel = (fn == FC_WR_SINGLE && ad == RECALC_LINE_ADDR) ? PARAM_NONE : 3'($random(seed));
      ask();
    end
    power_down = 1'b1;
    k = 0;
    repeat (6)
    begin
      @(negedge ref_clk);
      k += int'(store_req === 1'b1);
    end
    `CHK("store", 1, k)
    summarize();
  end
endmodule : modbus_exception_and_recalc_tb_top
